// ---- logic/tmcr_config_reg.sv ----
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module tmcr_config_reg #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_clk_en,
  input  wire logic                  i_soft_reset,
  input  wire logic                  i_hsel,
  input  wire logic     [ADDR_W-1:0] i_haddr,
  input  wire logic            [1:0] i_htrans,
  input  wire logic                  i_hwrite,
  input  wire logic            [2:0] i_hsize,
  input  wire logic           [31:0] i_hwdata,
  input  wire logic                  i_hready,
  output logic                [31:0] o_hrdata,
  output logic                       o_hreadyout,
  output logic                       o_hresp,
  input  wire logic                  i_enh_enable,
  input  wire logic                  i_alt_status_en,
  input  wire logic                  i_bc_enabled,
  input  wire logic                  i_bc_frame_busy,
  input  wire logic                  i_bc_msg_busy,
  input  wire logic                  i_rt_msg_busy,
  input  wire logic                  i_mon_enabled,
  input  wire logic                  i_mon_triggered,
  input  wire logic                  i_mon_active,
  input  wire logic                  i_msg_illegal,
  output tmcr_pkg::tmcr_mode_e       o_mode,
  output logic                [12:0] o_ctrl,
  output logic                       o_area_sel,
  output logic                       o_abort_msg
);
  import tmcr_pkg::*;

  localparam logic [ADDR_W-1:0] CFG_ADDR = ADDR_W'(CFG_BYTE_ADDR);

  logic  [15:0] cfg;
  logic  [15:0] next_cfg;
  logic         shown_area;
  logic         next_shown_area;
  logic         wr_pend;
  logic         next_wr_pend;
  logic         wr_hit;
  logic         next_wr_hit;
  logic  [31:0] rd_data;
  logic  [31:0] next_rd_data;
  logic         abort_msg;
  logic         next_abort_msg;
  logic         addr_take;
  logic         addr_hit;
  logic         area_busy;
  logic         leave_cond;
  logic  [15:0] wr_val;
  logic  [15:0] view;
  tmcr_mode_e   cur_mode;
  tmcr_mode_e   new_mode;
  tmcr_layout_e cur_lay;
  tmcr_layout_e new_lay;
  tmcr_layout_e view_lay;
  logic  [15:0] cur_wr_mask;
  logic  [15:0] new_wr_mask;
  logic  [15:0] view_wr_mask;
  logic  [15:0] view_ro_mask;
  logic  [15:0] status_bits;

  tmcr_mode_decode u_cur_decode (
    .i_terminal_select_bit   (cfg[BIT_TERM]),
    .i_monitor_select_bit    (cfg[BIT_MON]),
    .i_message_monitor_enable(cfg[BIT_MMT]),
    .i_enh_enable            (i_enh_enable),
    .i_alt_status_en         (i_alt_status_en),
    .o_mode                  (cur_mode),
    .o_layout                (cur_lay),
    .o_wr_mask               (cur_wr_mask),
    .o_ro_mask               ()
  );

  // Layout chosen by the value being written
  tmcr_mode_decode u_new_decode (
    .i_terminal_select_bit   (i_hwdata[BIT_TERM]),
    .i_monitor_select_bit    (i_hwdata[BIT_MON]),
    .i_message_monitor_enable(i_hwdata[BIT_MMT]),
    .i_enh_enable            (i_enh_enable),
    .i_alt_status_en         (i_alt_status_en),
    .o_mode                  (new_mode),
    .o_layout                (new_lay),
    .o_wr_mask               (new_wr_mask),
    .o_ro_mask               ()
  );

  // Layout of the value software will read next
  tmcr_mode_decode u_view_decode (
    .i_terminal_select_bit   (next_cfg[BIT_TERM]),
    .i_monitor_select_bit    (next_cfg[BIT_MON]),
    .i_message_monitor_enable(next_cfg[BIT_MMT]),
    .i_enh_enable            (i_enh_enable),
    .i_alt_status_en         (i_alt_status_en),
    .o_mode                  (),
    .o_layout                (view_lay),
    .o_wr_mask               (view_wr_mask),
    .o_ro_mask               (view_ro_mask)
  );

  assign addr_take   = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
  assign addr_hit    = (i_haddr == CFG_ADDR);
  assign o_hreadyout = i_clk_en;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = rd_data;
  assign o_mode      = cur_mode;
  assign o_ctrl      = cfg[BIT_MMT:0];
  assign o_area_sel  = shown_area;
  assign o_abort_msg = abort_msg;

  assign area_busy = i_bc_frame_busy || i_rt_msg_busy || (cur_mode == TMCR_MSG_MON && i_mon_active);

  always_comb begin
    case (view_lay)
      TMCR_LAY_BC:  status_bits = {13'h0000, i_bc_enabled, i_bc_frame_busy, i_bc_msg_busy};
      TMCR_LAY_MON: status_bits = {13'h0000, i_mon_enabled, i_mon_triggered, i_mon_active};
      TMCR_LAY_RT, TMCR_LAY_RT_ALT: status_bits = {15'h0000, i_rt_msg_busy};
      default:      status_bits = 16'h0000;
    endcase
  end

  // leaving terminal/monitor or controller mid message
  always_comb begin
    leave_cond = 1'b0;
    if (wr_pend && wr_hit) begin
      if ((cur_lay == TMCR_LAY_RT || cur_lay == TMCR_LAY_RT_ALT || cur_lay == TMCR_LAY_MON) &&
          (new_lay == TMCR_LAY_BC || new_lay == TMCR_LAY_IDLE) && i_rt_msg_busy) begin
        leave_cond = 1'b1;
      end
      if (cur_lay == TMCR_LAY_BC && new_lay == TMCR_LAY_IDLE && i_bc_msg_busy) begin
        leave_cond = 1'b1;
      end
    end
  end

  always_comb begin
    next_wr_pend    = wr_pend;
    next_wr_hit     = wr_hit;
    next_cfg        = cfg;
    next_shown_area = shown_area;
    next_abort_msg  = 1'b0;
    next_rd_data    = rd_data;
    wr_val          = cfg;
    view            = 16'h0000;
    if (i_clk_en) begin
      // host write in the data phase
      if (wr_pend && wr_hit) begin
        wr_val   = i_hwdata[15:0] & new_wr_mask;
        next_cfg = wr_val;
      end
      // set wins over a host write
      if (cur_lay == TMCR_LAY_RT_ALT && i_msg_illegal) begin
        next_cfg[BIT_MSG_ERR] = 1'b1;
      end
      if (!area_busy) begin
        next_shown_area = next_cfg[BIT_AREA];
      end
      next_abort_msg = leave_cond;
      next_wr_pend   = addr_take && i_hwrite;
      next_wr_hit    = addr_hit;
      if (addr_take && !i_hwrite) begin
        view = (next_cfg & view_wr_mask & ~view_ro_mask) | (status_bits & view_ro_mask);
        view[BIT_AREA] = next_shown_area;
        next_rd_data = addr_hit ? {16'h0000, view} : HRDATA_ZERO;
      end
    end
    if (i_soft_reset) begin
      next_cfg        = CFG_RESET;
      next_shown_area = CFG_RESET[BIT_AREA];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cfg        <= CFG_RESET;
      shown_area <= CFG_RESET[BIT_AREA];
      wr_pend    <= 1'b0;
      wr_hit     <= 1'b0;
      rd_data    <= HRDATA_ZERO;
      abort_msg  <= 1'b0;
    end else begin
      cfg        <= next_cfg;
      shown_area <= next_shown_area;
      wr_pend    <= next_wr_pend;
      wr_hit     <= next_wr_hit;
      rd_data    <= next_rd_data;
      abort_msg  <= next_abort_msg;
    end
  end

  default clocking dc @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  reset_mode_clear_a: assert property ($past(i_soft_reset) |-> !cfg[BIT_TERM] && !cfg[BIT_MON])
    else $error("mode bits not cleared by soft reset");
  idle_decode_a: assert property (cfg[BIT_TERM] && cfg[BIT_MON] |-> cur_mode == TMCR_IDLE)
    else $error("both mode bits set but not idle");
  bc_decode_a: assert property (!cfg[BIT_TERM] && !cfg[BIT_MON] |->
      cur_mode == (i_enh_enable ? TMCR_BC_ENH : TMCR_BC_STD))
    else $error("controller flavour wrong");
  mon_flavour_a: assert property (!cfg[BIT_TERM] && cfg[BIT_MON] |->
      cur_mode == ((cfg[BIT_MMT] && i_enh_enable) ? TMCR_MSG_MON : TMCR_WORD_MON))
    else $error("monitor flavour wrong");
  bc_flags_read_a: assert property (i_clk_en && addr_take && !i_hwrite && addr_hit && !wr_pend &&
      cur_lay == TMCR_LAY_BC && !i_msg_illegal && !i_soft_reset |=>
      o_hrdata[2:0] == ($past(i_enh_enable) ?
      {$past(i_bc_enabled), $past(i_bc_frame_busy), $past(i_bc_msg_busy)} : 3'h0))
    else $error("controller flags not read back");
  rt_flag_read_a: assert property (i_clk_en && addr_take && !i_hwrite && addr_hit && !wr_pend &&
      cur_lay == TMCR_LAY_RT && !i_soft_reset |=> o_hrdata[0] == ($past(i_enh_enable) && $past(i_rt_msg_busy)))
    else $error("terminal message flag wrong");
  combined_layout_a: assert property (cur_mode == TMCR_RT_MON |-> cur_lay != TMCR_LAY_MON)
    else $error("combined mode used monitor layout");
  alt_err_set_a: assert property (i_clk_en && cur_lay == TMCR_LAY_RT_ALT && i_msg_illegal && !i_soft_reset
      |=> cfg[BIT_MSG_ERR])
    else $error("illegal message did not set error bit");
  unmapped_zero_a: assert property (i_clk_en && addr_take && !i_hwrite && !addr_hit |=> o_hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  area_hold_a: assert property (i_clk_en && area_busy && !i_soft_reset |=> $stable(shown_area))
    else $error("area readback changed while busy");
  abort_pulse_a: assert property (i_clk_en && leave_cond |=> o_abort_msg ##1 (!o_abort_msg || $past(leave_cond)))
    else $error("abort not pulsed on mode change");

endmodule : tmcr_config_reg

// ---- inc/tmcr_pkg.sv ----
// Behaviour
// - Bits 15 and 14 pick the operating mode; both set means idle.
// - Both clear gives bus controller, enhanced when the enhanced-enable input is set.
// - Bit 12 with enhanced-enable picks message monitor, or combined terminal/monitor.
// - In controller layout bits 2..0 read live status and ignore writes, only when enhanced.
// - Terminal layout bit 0 reads message-in-progress, only when enhanced.
// - Combined terminal/monitor mode uses the terminal bit layouts.
// - Alternate-status terminal layout keeps eleven host status bits in 11..1.
// - Alternate-status mode sets bit 10 when a message is illegalized.
// - Register sits at index one; host writes only the write-mask bits of the layout and reads them plus its read-only status bits.
// - Hardware or software reset clears bits 15 and 14.
// - Area bit reads old value until the running frame or message ends.
// - Leaving terminal or monitor for controller or idle aborts a running message.
package tmcr_pkg;

  localparam int unsigned CFG_INDEX = 1;
  localparam int unsigned CFG_BYTE_ADDR = CFG_INDEX * 4;

  localparam int unsigned BIT_TERM = 15;
  localparam int unsigned BIT_MON = 14;
  localparam int unsigned BIT_AREA = 13;
  localparam int unsigned BIT_MMT = 12;
  localparam int unsigned BIT_MSG_ERR = 10;

  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] MASK_BASE = 16'hF000;
  localparam logic [15:0] MASK_BC_ENH = 16'hFFF8;
  localparam logic [15:0] MASK_RT_STD = 16'hFF00;
  localparam logic [15:0] MASK_RT_ENH = 16'hFF80;
  localparam logic [15:0] MASK_RT_ALT = 16'hFFFE;
  localparam logic [15:0] MASK_MON_ENH = 16'hFE80;
  localparam logic [15:0] RO_THREE = 16'h0007;
  localparam logic [15:0] RO_ONE = 16'h0001;
  localparam logic [15:0] RO_NONE = 16'h0000;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] HRDATA_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    TMCR_BC_STD   = 3'b000,
    TMCR_BC_ENH   = 3'b001,
    TMCR_WORD_MON = 3'b010,
    TMCR_MSG_MON  = 3'b011,
    TMCR_RT_STD   = 3'b100,
    TMCR_RT_ENH   = 3'b101,
    TMCR_RT_MON   = 3'b110,
    TMCR_IDLE     = 3'b111
  } tmcr_mode_e;

  typedef enum logic [2:0] {
    TMCR_LAY_BC     = 3'b000,
    TMCR_LAY_RT     = 3'b001,
    TMCR_LAY_RT_ALT = 3'b010,
    TMCR_LAY_MON    = 3'b011,
    TMCR_LAY_IDLE   = 3'b100
  } tmcr_layout_e;

endpackage : tmcr_pkg

// ---- logic/tmcr_mode_decode.sv ----
`timescale 1ns/1ps
module tmcr_mode_decode (
  input  wire logic                  i_terminal_select_bit,
  input  wire logic                  i_monitor_select_bit,
  input  wire logic                  i_message_monitor_enable,
  input  wire logic                  i_enh_enable,
  input  wire logic                  i_alt_status_en,
  output tmcr_pkg::tmcr_mode_e       o_mode,
  output tmcr_pkg::tmcr_layout_e     o_layout,
  output logic                [15:0] o_wr_mask,
  output logic                [15:0] o_ro_mask
);
  import tmcr_pkg::*;

  always_comb begin
    o_mode    = TMCR_IDLE;
    o_layout  = TMCR_LAY_IDLE;
    o_wr_mask = MASK_BASE;
    o_ro_mask = RO_NONE;
    case ({i_terminal_select_bit, i_monitor_select_bit})
      2'b00: begin
        o_mode    = i_enh_enable ? TMCR_BC_ENH : TMCR_BC_STD;
        o_layout  = TMCR_LAY_BC;
        o_wr_mask = i_enh_enable ? MASK_BC_ENH : MASK_BASE;
        o_ro_mask = i_enh_enable ? RO_THREE : RO_NONE;
      end
      2'b01: begin
        o_mode    = (i_message_monitor_enable && i_enh_enable) ? TMCR_MSG_MON : TMCR_WORD_MON;
        o_layout  = TMCR_LAY_MON;
        o_wr_mask = i_enh_enable ? MASK_MON_ENH : MASK_BASE;
        o_ro_mask = i_enh_enable ? RO_THREE : RO_NONE;
      end
      2'b10: begin
        if (!i_enh_enable) begin
          o_mode = TMCR_RT_STD;
        end else if (i_message_monitor_enable) begin
          o_mode = TMCR_RT_MON;
        end else begin
          o_mode = TMCR_RT_ENH;
        end
        if (i_enh_enable && i_alt_status_en) begin
          o_layout  = TMCR_LAY_RT_ALT;
          o_wr_mask = MASK_RT_ALT;
          o_ro_mask = RO_ONE;
        end else begin
          o_layout  = TMCR_LAY_RT;
          o_wr_mask = i_enh_enable ? MASK_RT_ENH : MASK_RT_STD;
          o_ro_mask = i_enh_enable ? RO_ONE : RO_NONE;
        end
      end
      default: begin
        o_mode    = TMCR_IDLE;
        o_layout  = TMCR_LAY_IDLE;
        o_wr_mask = MASK_BASE;
        o_ro_mask = RO_NONE;
      end
    endcase
  end

endmodule : tmcr_mode_decode

// ---- bench/tmcr_host_model.sv ----
`timescale 1ns/1ps
module tmcr_host_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata,
  output logic             o_hsel,
  output logic       [7:0] o_haddr,
  output logic       [1:0] o_htrans,
  output logic             o_hwrite,
  output logic       [2:0] o_hsize,
  output logic      [31:0] o_hwdata
);
  import tmcr_pkg::*;
  initial begin
    o_hsel = 1'b0;
    o_haddr = 8'h00;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize = 3'h2;
    o_hwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    o_hsel <= 1'b1;
    o_haddr <= a;
    o_htrans <= HTRANS_NONSEQ;
    o_hwrite <= wr;
    do @(posedge i_sys_clk); while (i_hready !== 1'b1);
    o_htrans <= 2'h0;
    o_hsel <= 1'b0;
    o_hwdata <= wr ? d : ~o_hwdata;
    do @(posedge i_sys_clk); while (i_hready !== 1'b1);
    r = i_hrdata;
    // Released data bus shows no stale value
    o_hwdata <= ~o_hwdata;
  endtask : xfer
endmodule : tmcr_host_model

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  import tmcr_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        srst = 1'b0;
  logic        enh = 1'b0;
  logic        alt = 1'b0;
  logic [2:0]  bcs = 3'h0;
  logic [2:0]  mns = 3'h0;
  logic        rtb = 1'b0;
  logic        ill = 1'b0;
  logic        hsel, hwrite, hready, hresp, abort_msg;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  tmcr_mode_e  mode;
  logic [15:0] w;
  logic [31:0] e;
  logic [12:0] ctrl;
  logic        area_sel;
  logic [15:0] corner [8] = '{16'h0000, 16'h0fff, 16'h4000, 16'h5fff, 16'h8000, 16'h9fff, 16'hc000, 16'hffff};
  int unsigned rv;
  int          n0, n_abort = 0, n_fail = 0, check_count = 0;

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (abort_msg === 1'b1) n_abort <= n_abort + 1;

  tmcr_host_model tmcr_host_model_i (.i_sys_clk(sys_clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
    .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));
  tmcr_config_reg tmcr_config_reg_i (.i_sys_clk(sys_clk), .i_reset(rst), .i_clk_en(clk_en), .i_soft_reset(srst),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_enh_enable(enh),
    .i_alt_status_en(alt), .i_bc_enabled(bcs[2]), .i_bc_frame_busy(bcs[1]), .i_bc_msg_busy(bcs[0]),
    .i_rt_msg_busy(rtb), .i_mon_enabled(mns[2]), .i_mon_triggered(mns[1]), .i_mon_active(mns[0]),
    .i_msg_illegal(ill), .o_mode(mode), .o_ctrl(ctrl), .o_area_sel(area_sel), .o_abort_msg(abort_msg));

  function automatic logic [31:0] exp_rd(input logic [15:0] v, input logic st = 1'b1);
    logic [15:0] m;
    logic [15:0] s;
    m = 16'hf000;
    s = 16'h0000;
    case (v[15:14])
      2'b00: if (enh) begin
        m = 16'hfff8;
        s = {13'h0000, bcs};
      end
      2'b01: if (enh) begin
        m = 16'hfe80;
        s = {13'h0000, mns};
      end
      2'b10: begin
        m = enh ? (alt ? 16'hfffe : 16'hff80) : 16'hff00;
        s = {15'h0000, rtb & enh};
      end
      default: ;
    endcase
    return {16'h0000, (v & m) | (s & {16{st}})};
  endfunction : exp_rd

  function automatic logic [31:0] exp_mode(input logic [15:0] v);
    case (v[15:14])
      2'b00: return enh ? 32'h0000_0001 : 32'h0000_0000;
      2'b01: return (v[12] & enh) ? 32'h0000_0003 : 32'h0000_0002;
      2'b10: return !enh ? 32'h0000_0004 : (v[12] ? 32'h0000_0006 : 32'h0000_0005);
      default: return 32'h0000_0007;
    endcase
  endfunction : exp_mode

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r;
    tmcr_host_model_i.xfer(1'b1, a, {16'h0000, d}, r);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    tmcr_host_model_i.xfer(1'b0, a, 32'h0000_0000, r);
    chk(nm, e, r);
  endtask : rd_chk

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    results();
  end

  initial begin
    rv = $urandom(32'hf904);
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd_chk("reset value", 8'h04, 32'h0000_0000);
    chk("reset mode", 32'h0000_0000, 32'(mode));
    $display("test reset done");
    for (int i = 0; i < 64; i++) begin
      w = (i < 16) ? corner[i / 2] : 16'($urandom);
      // Enhanced enable settles before the mode write
      enh <= (i < 16) ? i[0] : 1'($urandom);
      alt <= 1'($urandom);
      bcs <= 3'($urandom) & 3'h5;
      mns <= 3'($urandom) & 3'h6;
      @(posedge sys_clk);
      wr(8'h04, w);
      rd_chk("config", 8'h04, exp_rd(w));
      chk("mode", exp_mode(w), 32'(mode));
      chk("hresp", 32'h0000_0000, 32'(hresp));
      e = exp_rd(w, 1'b0);
      chk("ctrl", 32'(e[12:0]), 32'(ctrl));
      chk("area sel", 32'(w[13]), 32'(area_sel));
    end
    $display("test modes done");
    enh <= 1'b1;
    alt <= 1'b0;
    bcs <= 3'h0;
    mns <= 3'h0;
    @(posedge sys_clk);
    wr(8'h04, 16'h8000);
    rtb <= 1'b1;
    wr(8'h04, 16'ha000);
    rd_chk("area busy", 8'h04, 32'h0000_8001);
    chk("area sel busy", 32'h0000_0000, 32'(area_sel));
    rtb <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd_chk("area done", 8'h04, 32'h0000_a000);
    chk("area sel done", 32'h0000_0001, 32'(area_sel));
    $display("test area done");
    n0 = n_abort;
    rtb <= 1'b1;
    wr(8'h04, 16'h0000);
    repeat (3) @(posedge sys_clk);
    chk("abort", 32'h0000_0001, n_abort - n0);
    rtb <= 1'b0;
    wr(8'h04, 16'h8000);
    n0 = n_abort;
    wr(8'h04, 16'hc000);
    repeat (3) @(posedge sys_clk);
    chk("no abort", 32'h0000_0000, n_abort - n0);
    wr(8'h04, 16'h4000);
    rtb <= 1'b1;
    n0 = n_abort;
    wr(8'h04, 16'hc000);
    repeat (3) @(posedge sys_clk);
    chk("monitor abort", 32'h0000_0001, n_abort - n0);
    $display("test abort done");
    alt <= 1'b1;
    rtb <= 1'b1;
    @(posedge sys_clk);
    wr(8'h04, 16'h8aaa);
    rd_chk("alt status", 8'h04, 32'h0000_8aab);
    ill <= 1'b1;
    @(posedge sys_clk);
    ill <= 1'b0;
    rd_chk("illegal", 8'h04, 32'h0000_8eab);
    wr(8'h08, 16'hffff);
    rd_chk("unmapped", 8'h08, 32'h0000_0000);
    rd_chk("kept", 8'h04, 32'h0000_8eab);
    $display("test alt status done");
    rtb <= 1'b0;
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    clk_en <= 1'b0;
    fork
      rd_chk("soft reset", 8'h04, 32'h0000_0000);
      begin
        repeat (5) @(posedge sys_clk);
        clk_en <= 1'b1;
      end
    join
    chk("soft mode", 32'h0000_0001, 32'(mode));
    $display("test soft reset done");
    results();
  end
endmodule : tb
